// ---- shared/dcpwm_defs.svh ----
// Constants of the dual channel PWM remap block: offsets, field positions, reset values.
// Assumes an 8-bit APB byte address and 32-bit data; included by bare name.
`ifndef DCPWM_DEFS_SVH
`define DCPWM_DEFS_SVH

// Control block indices; the byte address is four times the index.
`define DCPWM_CB_CTRL_IDX      1
`define DCPWM_CB_PTR_IDX       2
`define DCPWM_CB_ADD_IDX       4
`define DCPWM_CB1_BASE_IDX     8

// Byte addresses of the remaining registers; pointers use the same map.
`define DCPWM_ASSERT_TIME_ADDR   8'h40
`define DCPWM_DEASSERT_TIME_ADDR 8'h44
`define DCPWM_CH0_CTRL_ADDR      8'h48
`define DCPWM_CH1_CTRL_ADDR      8'h4c
`define DCPWM_TIMER_CTRL_ADDR    8'h50
`define DCPWM_TIMER_VALUE_ADDR   8'h54
`define DCPWM_SERVICE_SEL_ADDR   8'h58
`define DCPWM_SERVER_EN_ADDR     8'h5c
`define DCPWM_PIN_DIR_ADDR       8'h60
`define DCPWM_PIN_FUNC_ADDR      8'h64
`define DCPWM_PIN_VAL_ADDR       8'h68
`define DCPWM_STATUS_ADDR        8'h6c
`define DCPWM_SCRATCH_TOP        3'h4
`define DCPWM_SCRATCH_WORDS      8

// Service control byte fields.
`define DCPWM_MODE_LSB   5
`define DCPWM_MODE_PWM   3'h2
`define DCPWM_METHOD_BIT 1
`define DCPWM_FLAG_BIT   0
`define DCPWM_CTRL_MASK  8'he3

// Channel control fields.
`define DCPWM_CCTL_REMAP_BIT 8
`define DCPWM_CCTL_CMP_BIT   6
`define DCPWM_CCTL_SET_BIT   5
`define DCPWM_CCTL_CLR_BIT   4
`define DCPWM_CCTL_REEN_BIT  3

// Timer control fields.
`define DCPWM_TCTL_EN_BIT    7
`define DCPWM_TCTL_UP_BIT    6

// Service select bits per channel and status fields.
`define DCPWM_SEL_ASSERT_BIT   4
`define DCPWM_SEL_DEASSERT_BIT 3
`define DCPWM_STAT_LEVEL_BIT   4
`define DCPWM_STAT_BUSY_BIT    5

// Reset values.
`define DCPWM_RST_PIN_DIR 2'h3
`define DCPWM_RST_PIN_VAL 2'h3
`define DCPWM_RST_OE_N    2'h3

`endif

// ---- shared/dcpwm_pkg.sv ----
// Types of the dual channel PWM remap block: server states and module state records.
// Assumes dcpwm_defs.svh is on the include path.
`include "dcpwm_defs.svh"

package dcpwm_pkg;

  // Transaction server states, one-hot.
  typedef enum logic [2:0] {
    DCPWM_SRV_IDLE  = 3'b001,
    DCPWM_SRV_READ  = 3'b010,
    DCPWM_SRV_WRITE = 3'b100
  } dcpwm_srv_e;

  // State of the prescaled timer.
  typedef struct packed {
    logic [15:0] count;
    logic [6:0]  presc;
    logic        tick;
  } dcpwm_timer_s;

  // State of one compare channel.
  typedef struct packed {
    logic match;
  } dcpwm_cmp_s;

  // State of the core.
  typedef struct packed {
    logic [1:0][7:0]                         cb_ctrl;
    logic [1:0][15:0]                        cb_ptr;
    logic [1:0][15:0]                        cb_add;
    logic [1:0][15:0]                        ev_time;
    logic [1:0][8:0]                         ch_ctrl;
    logic [7:0]                              tctl;
    logic [7:0]                              sel;
    logic                                    srv_en;
    logic [1:0]                              pin_dir;
    logic [1:0]                              pin_func;
    logic [1:0]                              pin_val;
    logic [1:0]                              pend;
    logic [1:0]                              srv_req;
    dcpwm_srv_e                              srv_state;
    logic                                    srv_ch;
    logic [15:0]                             srv_word;
    logic [`DCPWM_SCRATCH_WORDS-1:0][15:0]   scratch;
    logic                                    pwm_level;
    logic [1:0]                              pin_out;
    logic [1:0]                              pin_oe_n;
    logic [1:0]                              match_req;
    logic                                    pready;
    logic                                    pslverr;
    logic [31:0]                             prdata;
    logic                                    timer_load;
    logic [15:0]                             timer_load_val;
  } dcpwm_core_s;

endpackage : dcpwm_pkg

// ---- rtl/dcpwm_timer.sv ----
// Free-running 16-bit timer with a power-of-two prescaler and up or down count.
// Assumes controls come from registers in the same clock domain.
module dcpwm_timer import dcpwm_pkg::*; (
  // Clock and reset.
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  // Control.
  input  wire logic        enable,
  input  wire logic        count_up,
  input  wire logic [2:0]  presc_sel,
  input  wire logic        load,
  input  wire logic [15:0] load_value,
  // Timer value and update strobe.
  output logic      [15:0] count,
  output logic             tick
);

  dcpwm_timer_s s;
  dcpwm_timer_s next_s;
  logic [6:0]   limit;

  // Prescaler wraps after two to the power of the select, then steps the count.
  always_comb begin
    limit  = 7'((8'h01 << presc_sel) - 8'h01);
    next_s = s;
    next_s.tick = 1'b0;
    if (load) begin
      next_s.count = load_value;
      next_s.presc = 7'h00;
    end else if (enable) begin
      if (s.presc >= limit) begin
        next_s.presc = 7'h00;
        next_s.count = count_up ? s.count + 16'h0001 : s.count - 16'h0001; // Wraps modulo 2^16.
        next_s.tick  = 1'b1;
      end else begin
        next_s.presc = s.presc + 7'h01;
      end
    end
  end

  // State register.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign count = s.count;
  assign tick  = s.tick;

endmodule : dcpwm_timer

// ---- rtl/dcpwm_compare.sv ----
// One compare channel: flags a match when the timer steps onto the event time.
// Assumes count and tick change together, one cycle after the timer steps.
module dcpwm_compare import dcpwm_pkg::*; #(
  parameter int WIDTH = 16
) (
  // Clock and reset.
  input  wire logic             ref_clk,
  input  wire logic             reset_n,
  // Timer and channel setup.
  input  wire logic             tick,
  input  wire logic [WIDTH-1:0] count,
  input  wire logic [WIDTH-1:0] event_time,
  input  wire logic             enable,
  // Match pulse.
  output logic                  match
);

  dcpwm_cmp_s s;
  dcpwm_cmp_s next_s;

  // Only a fresh timer value can match, so a stopped timer never repeats a match.
  always_comb begin
    next_s       = s;
    next_s.match = tick && enable && (count == event_time);
  end

  // State register.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign match = s.match;

endmodule : dcpwm_compare

// ---- rtl/dcpwm_core.sv ----
// Dual channel PWM generator with a read-add-write transaction server, APB slave.
// Assumes APB signals synchronous to ref_clk and pin_in already synchronous.
//
// What this block does
// - Mode field 010 selects waveform service.
// - Remap always adds the single period addend.
// - Flag still inverts after every service cycle.
// - Written flag bit sets its starting value.
// - Reading flag returns its present hardware value.
// - Pointer may address either event time or a scratch word; other page-zero locations read as zero and are not written.
// - Block holds control, pointer, addend at 1,2,4.
// - Each match service adds period to event time.
// - First channel sets output, second clears; both request.
// - One request per channel per period.
// - Output stays high until deassert match.
// - Assert channel pin stays plain port pin.
// - Service reads target, adds, writes back.
`include "dcpwm_defs.svh"
module dcpwm_core import dcpwm_pkg::*; (
  // Clock and reset.
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  // APB slave.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // Port pins: bit 0 is the plain pin, bit 1 the waveform pin.
  input  wire logic [1:0]  pin_in,
  output logic      [1:0]  pin_out,
  output logic      [1:0]  pin_oe_n,
  // Compare match requests, one pulse per match.
  output logic      [1:0]  match_req
);

  dcpwm_core_s s;
  dcpwm_core_s next_s;
  logic [15:0] timer_count;
  logic        timer_tick;
  logic [1:0]  match;

  // Byte address of a control block field.
  function automatic logic [7:0] cb_addr(input int c, input int idx);
    cb_addr = 8'((idx + c * `DCPWM_CB1_BASE_IDX) * 4);
  endfunction : cb_addr

  // True when a control block asks for remap waveform service.
  function automatic logic mode_ok(input logic [7:0] ctrl);
    mode_ok = (ctrl[7:`DCPWM_MODE_LSB] == `DCPWM_MODE_PWM) && !ctrl[`DCPWM_METHOD_BIT];
  endfunction : mode_ok

  // Word seen by the server at a pointer; outside page zero it reads as zero.
  function automatic logic [15:0] tgt_read(input dcpwm_core_s st, input logic [15:0] ptr);
    tgt_read = 16'h0000;
    if (ptr[15:8] != 8'h00) begin
      tgt_read = 16'h0000;
    end else if (ptr[7:0] == `DCPWM_ASSERT_TIME_ADDR) begin
      tgt_read = st.ev_time[0];
    end else if (ptr[7:0] == `DCPWM_DEASSERT_TIME_ADDR) begin
      tgt_read = st.ev_time[1];
    end else if (ptr[7:5] == `DCPWM_SCRATCH_TOP) begin
      tgt_read = st.scratch[ptr[4:2]];
    end
  endfunction : tgt_read

  // Shared timer.
  dcpwm_timer u_timer (
    .ref_clk    (ref_clk),
    .reset_n    (reset_n),
    .enable     (s.tctl[`DCPWM_TCTL_EN_BIT]),
    .count_up   (s.tctl[`DCPWM_TCTL_UP_BIT]),
    .presc_sel  (s.tctl[2:0]),
    .load       (s.timer_load),
    .load_value (s.timer_load_val),
    .count      (timer_count),
    .tick       (timer_tick)
  );

  // One compare unit per channel.
  for (genvar g = 0; g < 2; g++) begin : g_cmp
    dcpwm_compare #(.WIDTH(16)) u_cmp (
      .ref_clk    (ref_clk),
      .reset_n    (reset_n),
      .tick       (timer_tick),
      .count      (timer_count),
      .event_time (s.ev_time[g]),
      .enable     (s.ch_ctrl[g][`DCPWM_CCTL_CMP_BIT]),
      .match      (match[g])
    );
  end

  // Next state: bus writes first, then the server, then match events, so that
  // hardware updates win over a software write landing in the same cycle.
  always_comb begin
    logic [31:0] rd;
    logic        hit;
    logic        wr;
    logic        ch;
    logic [15:0] sum;
    logic [15:0] ptr;
    logic        set_any;
    logic        clr_any;
    logic        drive0;
    logic        drive1;
    rd      = 32'h0000_0000;
    hit     = 1'b0;
    wr      = psel && penable && s.pready && pwrite;
    ch      = s.srv_ch;
    sum     = 16'h0000;
    ptr     = s.cb_ptr[s.srv_ch];
    set_any = 1'b0;
    clr_any = 1'b0;
    drive0  = 1'b0;
    drive1  = 1'b0;
    next_s  = s;
    next_s.pready     = 1'b0;
    next_s.pslverr    = 1'b0;
    next_s.timer_load = 1'b0;
    next_s.match_req  = match;

    // Control blocks; reserved control byte bits read as zero.
    for (int c = 0; c < 2; c++) begin
      if (paddr == cb_addr(c, `DCPWM_CB_CTRL_IDX)) begin
        hit = 1'b1;
        rd  = {24'h000000, s.cb_ctrl[c]}; // Present flag value.
        if (wr) begin
          next_s.cb_ctrl[c] = pwdata[7:0] & `DCPWM_CTRL_MASK; // Seeds the flag.
        end
      end
      if (paddr == cb_addr(c, `DCPWM_CB_PTR_IDX)) begin
        hit = 1'b1;
        rd  = {16'h0000, s.cb_ptr[c]};
        if (wr) begin
          next_s.cb_ptr[c] = pwdata[15:0];
        end
      end
      if (paddr == cb_addr(c, `DCPWM_CB_ADD_IDX)) begin
        hit = 1'b1;
        rd  = {16'h0000, s.cb_add[c]};
        if (wr) begin
          next_s.cb_add[c] = pwdata[15:0];
        end
      end
    end

    // Remaining registers.
    if (paddr == `DCPWM_ASSERT_TIME_ADDR) begin
      hit = 1'b1;
      rd  = {16'h0000, s.ev_time[0]};
      if (wr) next_s.ev_time[0] = pwdata[15:0];
    end else if (paddr == `DCPWM_DEASSERT_TIME_ADDR) begin
      hit = 1'b1;
      rd  = {16'h0000, s.ev_time[1]};
      if (wr) next_s.ev_time[1] = pwdata[15:0];
    end else if (paddr == `DCPWM_CH0_CTRL_ADDR) begin
      hit = 1'b1;
      rd  = {23'h000000, s.ch_ctrl[0]};
      if (wr) next_s.ch_ctrl[0] = pwdata[8:0];
    end else if (paddr == `DCPWM_CH1_CTRL_ADDR) begin
      hit = 1'b1;
      rd  = {23'h000000, s.ch_ctrl[1]};
      if (wr) next_s.ch_ctrl[1] = pwdata[8:0];
    end else if (paddr == `DCPWM_TIMER_CTRL_ADDR) begin
      hit = 1'b1;
      rd  = {24'h000000, s.tctl};
      if (wr) next_s.tctl = pwdata[7:0];
    end else if (paddr == `DCPWM_TIMER_VALUE_ADDR) begin
      hit = 1'b1;
      rd  = {16'h0000, timer_count};
      if (wr) begin
        next_s.timer_load     = 1'b1; // Preload, such as all ones before the start.
        next_s.timer_load_val = pwdata[15:0];
      end
    end else if (paddr == `DCPWM_SERVICE_SEL_ADDR) begin
      hit = 1'b1;
      rd  = {24'h000000, s.sel};
      if (wr) next_s.sel = pwdata[7:0];
    end else if (paddr == `DCPWM_SERVER_EN_ADDR) begin
      hit = 1'b1;
      rd  = {31'h00000000, s.srv_en};
      if (wr) next_s.srv_en = pwdata[0];
    end else if (paddr == `DCPWM_PIN_DIR_ADDR) begin
      hit = 1'b1;
      rd  = {30'h00000000, s.pin_dir};
      if (wr) next_s.pin_dir = pwdata[1:0];
    end else if (paddr == `DCPWM_PIN_FUNC_ADDR) begin
      hit = 1'b1;
      rd  = {30'h00000000, s.pin_func};
      if (wr) next_s.pin_func = pwdata[1:0];
    end else if (paddr == `DCPWM_PIN_VAL_ADDR) begin
      hit = 1'b1;
      rd  = {30'h00000000, s.pin_val};
      if (wr) next_s.pin_val = pwdata[1:0];
    end else if (paddr == `DCPWM_STATUS_ADDR) begin
      hit = 1'b1;
      rd  = {24'h000000, pin_in, (s.srv_state != DCPWM_SRV_IDLE), s.pwm_level, 2'h0, s.pend};
      if (wr) next_s.pend = s.pend & ~pwdata[1:0]; // Write one to clear.
    end else if (paddr[7:5] == `DCPWM_SCRATCH_TOP) begin
      hit = 1'b1;
      rd  = {16'h0000, s.scratch[paddr[4:2]]};
      if (wr) next_s.scratch[paddr[4:2]] = pwdata[15:0];
    end

    // Read data is captured in the setup cycle; the answer always takes one cycle.
    if (psel && !penable) begin
      next_s.pready  = 1'b1;
      next_s.prdata  = rd;
      next_s.pslverr = !hit;
    end

    // Transaction server: the assert channel wins when both wait.
    case (s.srv_state)
      DCPWM_SRV_IDLE: begin
        if (s.srv_req != 2'h0) begin
          ch = !s.srv_req[0];
          next_s.srv_ch      = ch;
          next_s.srv_req[ch] = 1'b0;
          if (mode_ok(s.cb_ctrl[ch])) begin
            next_s.srv_state = DCPWM_SRV_READ; // Other modes are dropped.
          end
        end
      end
      DCPWM_SRV_READ: begin
        next_s.srv_word  = tgt_read(s, ptr);
        next_s.srv_state = DCPWM_SRV_WRITE;
      end
      DCPWM_SRV_WRITE: begin
        // The flag never picks the addend here.
        sum = 16'(s.srv_word + s.cb_add[ch]);
        if (ptr[15:8] == 8'h00) begin
          if (ptr[7:0] == `DCPWM_ASSERT_TIME_ADDR) begin
            next_s.ev_time[0] = sum;
          end else if (ptr[7:0] == `DCPWM_DEASSERT_TIME_ADDR) begin
            next_s.ev_time[1] = sum;
          end else if (ptr[7:5] == `DCPWM_SCRATCH_TOP) begin
            next_s.scratch[ptr[4:2]] = sum;
          end
        end
        next_s.cb_ctrl[ch][`DCPWM_FLAG_BIT] = !s.cb_ctrl[ch][`DCPWM_FLAG_BIT];
        next_s.srv_state = DCPWM_SRV_IDLE;
      end
      default: begin
        next_s.srv_state = DCPWM_SRV_IDLE;
      end
    endcase

    // Match events: route to the server or leave a normal request pending.
    for (int c = 0; c < 2; c++) begin
      if (match[c]) begin
        if (!s.ch_ctrl[c][`DCPWM_CCTL_REEN_BIT]) begin
          next_s.ch_ctrl[c][`DCPWM_CCTL_CMP_BIT] = 1'b0;
        end
        if (s.srv_en && s.sel[c == 0 ? `DCPWM_SEL_ASSERT_BIT : `DCPWM_SEL_DEASSERT_BIT]) begin
          next_s.srv_req[c] = 1'b1;
        end else begin
          next_s.pend[c] = 1'b1; // Set wins over a clear.
        end
        set_any = set_any || s.ch_ctrl[c][`DCPWM_CCTL_SET_BIT];
        clr_any = clr_any || s.ch_ctrl[c][`DCPWM_CCTL_CLR_BIT];
      end
    end

    // Waveform level; while the pin is a port pin its data presets the level.
    if (!s.pin_func[1]) begin
      next_s.pwm_level = s.pin_val[1];
    end else if (clr_any) begin
      next_s.pwm_level = 1'b0; // Clear wins so coincident edges give zero duty.
    end else if (set_any) begin
      next_s.pwm_level = 1'b1; // Held until the next clearing match.
    end

    // Pins; with the direction bit set a pin is open drain and only pulls low.
    drive0 = s.pin_val[0]; // The assert channel owns no pin.
    drive1 = s.pin_func[1] ? s.pwm_level : s.pin_val[1];
    next_s.pin_out  = {drive1, drive0};
    next_s.pin_oe_n = {s.pin_dir[1] && drive1, s.pin_dir[0] && drive0};
  end

  // State register.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      s           <= '0;
      s.srv_state <= DCPWM_SRV_IDLE;
      s.pin_dir   <= `DCPWM_RST_PIN_DIR;
      s.pin_val   <= `DCPWM_RST_PIN_VAL;
      s.pin_oe_n  <= `DCPWM_RST_OE_N;
    end else begin
      s <= next_s;
    end
  end

  assign pready    = s.pready;
  assign prdata    = s.prdata;
  assign pslverr   = s.pslverr;
  assign pin_out   = s.pin_out;
  assign pin_oe_n  = s.pin_oe_n;
  assign match_req = s.match_req;

  // Checks on the design's own behaviour.
  default clocking cb_main @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  chk_mode_gate: assert property (
    s.srv_state == DCPWM_SRV_READ |-> mode_ok(s.cb_ctrl[s.srv_ch]))
    else $error("Server ran on a block that is not remap mode.");

  chk_flag_inverts: assert property (
    s.srv_state == DCPWM_SRV_WRITE |=>
      s.cb_ctrl[$past(s.srv_ch)][`DCPWM_FLAG_BIT] != $past(s.cb_ctrl[s.srv_ch][`DCPWM_FLAG_BIT]))
    else $error("Flag did not invert at the end of a service cycle.");

  chk_sum_written: assert property (
    s.srv_state == DCPWM_SRV_WRITE &&
    s.cb_ptr[s.srv_ch] == {8'h00, `DCPWM_ASSERT_TIME_ADDR} |=>
      s.ev_time[0] == 16'($past(s.srv_word) + $past(s.cb_add[s.srv_ch])))
    else $error("Event time is not the read word plus the addend.");

  chk_service_steps: assert property (
    s.srv_state == DCPWM_SRV_READ |=> s.srv_state == DCPWM_SRV_WRITE ##1
      s.srv_state == DCPWM_SRV_IDLE)
    else $error("Service cycle did not take read then write.");

  chk_request_served: assert property (
    match[0] && s.srv_en && s.sel[`DCPWM_SEL_ASSERT_BIT] && mode_ok(s.cb_ctrl[0]) |->
      ##[1:4] (s.srv_state == DCPWM_SRV_READ && !s.srv_ch))
    else $error("Assert channel match was not served in time.");

  chk_normal_pending: assert property (
    match[1] && !(s.srv_en && s.sel[`DCPWM_SEL_DEASSERT_BIT]) |=> s.pend[1])
    else $error("Unserved deassert match left no pending request.");

  chk_assert_sets: assert property (
    match[0] && s.ch_ctrl[0][`DCPWM_CCTL_SET_BIT] && !match[1] && s.pin_func[1] |=>
      s.pwm_level ##1 pin_out[1])
    else $error("Assert match did not raise the waveform pin.");

  chk_deassert_clears: assert property (
    match[1] && s.ch_ctrl[1][`DCPWM_CCTL_CLR_BIT] && s.pin_func[1] |=> !s.pwm_level)
    else $error("Deassert match did not lower the output.");

  chk_level_holds: assert property (
    s.pin_func[1] && match == 2'h0 |=> $stable(s.pwm_level))
    else $error("Output changed without a match.");

  chk_plain_pin: assert property (
    $past(reset_n) |-> pin_out[0] == $past(s.pin_val[0]))
    else $error("Plain port pin does not follow its data bit.");

  chk_match_req: assert property (
    match == 2'h1 |=> match_req == 2'h1 ##1 match_req == $past(match))
    else $error("Match request pulse missing.");

  cov_assert_service: cover property (s.srv_state == DCPWM_SRV_WRITE && !s.srv_ch);
  cov_deassert_service: cover property (s.srv_state == DCPWM_SRV_WRITE && s.srv_ch);
  cov_normal_pending: cover property (match[1] ##1 s.pend[1]);
  cov_sum_wraps: cover property (
    s.srv_state == DCPWM_SRV_WRITE && 17'(s.srv_word) + 17'(s.cb_add[s.srv_ch]) > 17'h0ffff);

endmodule : dcpwm_core

// ---- testbench/dcpwm_load.sv ----
// Load model on the waveform pin: pull-up wire and edge-to-edge width counters.
// Assumes the block drives the pin on ref_clk and releases it with oe_n high.
module dcpwm_load (
  // Clock.
  input  wire logic ref_clk,
  // Pin drive from the block.
  input  wire logic drive,
  input  wire logic drive_oe_n,
  // Wire level and widths in ref_clk cycles.
  output logic      level,
  output int        high_cycles,
  output int        period_cycles
);
  timeunit 1ns;
  timeprecision 1ps;
  int   cnt_high = 0;
  int   cnt_per  = 0;
  logic last     = 1'b1;
  // A released pin is pulled high, so it never shows a stale driven value.
  assign level = drive_oe_n ? 1'b1 : drive;
  // Widths restart on each rising edge; the first widths after setup are not meaningful.
  always @(posedge ref_clk) begin
    cnt_per <= cnt_per + 1;
    if (level) cnt_high <= cnt_high + 1;
    if (level && !last) begin
      period_cycles <= cnt_per;
      cnt_per       <= 1;
      cnt_high      <= 1;
    end
    if (!level && last) high_cycles <= cnt_high;
    last <= level;
  end
endmodule : dcpwm_load

// ---- testbench/test_dual_channel_pwm_remap_service.sv ----
// Self-checking bench of the remap PWM core: APB setup, service results, pin widths.
// Assumes the core answers APB one cycle after setup and the load model measures the pin.
module test_dual_channel_pwm_remap_service;
  timeunit 1ns;
  timeprecision 1ps;
  logic             ref_clk = 1'b0;
  logic             reset_n = 1'b0;
  logic             psel = 1'b0;
  logic             penable = 1'b0;
  logic             pwrite = 1'b0;
  logic [7:0]       paddr = 8'h00;
  logic [31:0]      pwdata = 32'h0;
  logic [31:0]      prdata, rd;
  logic             pready, pslverr, err;
  wire logic [1:0]  pin_in;
  logic [1:0]       pin_out, pin_oe_n, match_req;
  int               num_errors = 0;
  int               compares = 0;
  int               cycles = 0;
  int               hi, per;
  logic [31:0]      seed = 32'h52;
  logic [15:0]      p, t1, d, e;

  dcpwm_core dcpwm_core_inst (.ref_clk(ref_clk), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe_n(pin_oe_n), .match_req(match_req));
  dcpwm_load dcpwm_load_inst (.ref_clk(ref_clk), .drive(pin_out[1]),
    .drive_oe_n(pin_oe_n[1]), .level(pin_in[1]), .high_cycles(hi), .period_cycles(per));
  // The plain pin has the same pull-up as the waveform pin.
  assign pin_in[0] = pin_oe_n[0] ? 1'b1 : pin_out[0];

  // Clock of 25 ns and a hang limit well above the expected run.
  initial forever #12.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      num_errors++;
      summarize();
    end
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  // Event times wrap with the 16-bit timer.
  function automatic logic [15:0] nxt(input logic [15:0] t, input logic [15:0] a);
    return t + a;
  endfunction : nxt
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
    compares++;
    if (s !== x) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", n, x, s);
    end
  endtask : chk
  // One APB transfer; the request stands until pready is sampled high.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] dat);
    @(posedge ref_clk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= dat;
    penable <= 1'b0;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1) @(posedge ref_clk);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] dat);
    apb(1'b1, a, dat);
  endtask : wr
  task automatic rc(input logic [7:0] a, input logic [31:0] x, input logic xe);
    apb(1'b0, a, 32'h0);
    chk($sformatf("reg %h", a), rd, x);
    chk("slverr", 32'(err), 32'(xe));
  endtask : rc
  // Waits for one match pulse, then lets the service finish.
  task automatic wm(input int i);
    @(posedge ref_clk);
    while (match_req[i] !== 1'b1) @(posedge ref_clk);
    repeat (6) @(posedge ref_clk);
  endtask : wm
  task automatic summarize();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : summarize

  // Reset, register checks, remap PWM setup, service and width checks, duty change.
  initial begin
    p  = 16'h20 + 16'(rnd() & 32'h1f);
    t1 = 16'h8 + 16'(rnd() & 32'h7);
    d  = 16'h1 + 16'(rnd() & 32'h7);
    repeat (6) @(posedge ref_clk);
    reset_n <= 1'b1;
    rc(8'h60, 32'h3, 1'b0);
    rc(8'h68, 32'h3, 1'b0);
    chk("oe_n", 32'(pin_oe_n), 32'h3);
    rc(8'hfc, 32'h0, 1'b1);
    wr(8'h5c, 32'h0);
    wr(8'h04, 32'h41);
    rc(8'h04, 32'h41, 1'b0);
    wr(8'h04, 32'h40);
    wr(8'h08, 32'h40);
    wr(8'h10, 32'(p));
    wr(8'h24, 32'h40);
    wr(8'h28, 32'h44);
    wr(8'h30, 32'(p));
    wr(8'h40, 32'h0);
    wr(8'h44, 32'(t1));
    wr(8'h48, 32'h68);
    wr(8'h4c, 32'h158);
    wr(8'h54, 32'hffff);
    wr(8'h60, 32'h0);
    wr(8'h68, 32'h2);
    wr(8'h64, 32'h2);
    wr(8'h58, 32'h18);
    wr(8'h5c, 32'h1);
    wr(8'h50, 32'hc2);
    wm(0);
    rc(8'h40, 32'(p), 1'b0);
    rc(8'h04, 32'h41, 1'b0);
    wm(1);
    rc(8'h44, 32'(nxt(t1, p)), 1'b0);
    rc(8'h24, 32'h41, 1'b0);
    wm(0);
    wm(0);
    chk("high", 32'(hi), 32'(t1) << 2);
    chk("period", 32'(per), 32'(p) << 2);
    chk("pin0", 32'(pin_out[0]), 32'h0);
    chk("oe_n", 32'(pin_oe_n), 32'h0);
    wr(8'h58, 32'h10);
    wm(1);
    rc(8'h6c, 32'h2, 1'b0);
    apb(1'b0, 8'h44, 32'h0);
    e = nxt(rd[15:0], p + d);
    wr(8'h44, 32'(e));
    wr(8'h58, 32'h18);
    wr(8'h6c, 32'h2);
    rc(8'h6c, 32'h0, 1'b0);
    wm(0);
    wm(0);
    chk("duty", 32'(hi), 32'(t1 + d) << 2);
    rc(8'h44, 32'(nxt(e, p)), 1'b0);
    // A control byte with mode 011 must leave the next match unserved.
    wr(8'h04, 32'h60);
    wm(0);
    rc(8'h40, 32'(p) * 5, 1'b0);
    rc(8'h04, 32'h60, 1'b0);
    summarize();
  end
endmodule : test_dual_channel_pwm_remap_service
